// ==== hw/irq_controller.v ====
// Interrupt mask, pending status, software interrupt and line drive logic with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

module irq_controller #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // AHB-Lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Error sources from the system pending logic, active high levels
  input wire errPio,
  input wire errDma,
  input wire errSerr,
  input wire errProc,
  // Bus reset input, active high, and pulse that clears its latched detection
  input wire busResetIn,
  input wire busResetClear,
  // Counter-timer interrupts, active high levels
  input wire procCounterIrq,
  input wire sysCounterIrq,
  // Shared open-drain interrupt lines, wired level, active low
  input wire [7:0] intLineIn_n,
  output reg [7:0] intLineOut,
  output reg [7:0] intLineOe,
  // Level code to the processor core
  output reg [3:0] coreInterruptLevel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] mask_ff;
  reg [14:0] softPend_ff;
  reg busResetSeen_ff;
  reg [15:0] assignLow_ff;
  reg [15:0] assignHigh_ff;
  reg [7:0] counterAssign_ff;
  reg [7:0] lineDrive_ff;
  reg [3:0] levelSample_ff;
  reg wrPending_ff;
  reg [9:0] wrIndex_ff;

  reg [31:0] nxt_mask;
  reg [14:0] nxt_softPend;
  reg [31:0] rdValue;

  wire addrPhase;
  wire [9:0] addrIndex;
  wire wrMaskSet;
  wire wrMaskClear;
  wire wrSoftSet;
  wire wrSoftClear;
  wire wrAssignLow;
  wire wrAssignHigh;
  wire wrCounterAssign;
  wire wrLineDrive;
  wire maskAll;
  wire [9:0] lineActive;
  wire [39:0] lineLevel;
  wire [149:0] levelHotAll;
  reg [14:0] hwLevels;
  wire [14:0] hwUnmasked;
  wire [14:0] softUnmasked;
  wire [31:0] pendingWord;
  wire [3:0] levelCode;
  wire [3:0] gatedLevel;
  wire [4:0] errPending;
  wire errAny;
  integer i;

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  // Only word transfers are defined; hsize is accepted but not checked
  assign addrPhase = hsel & htrans[1] & hready;
  assign addrIndex = haddr[11:2];

  always @(posedge sys_clk) begin
    if (!rstn) begin
      wrPending_ff <= 1'b0;
      wrIndex_ff <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // Zero wait states: every transfer completes in its first data cycle
      wrPending_ff <= addrPhase & hwrite;
      wrIndex_ff <= addrIndex;
      hreadyout <= 1'b1;
      // Response stays OKAY: no register refuses an access
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write strobes, valid in the data phase while hwdata stands
  // ----------------------------------------------------------------
  assign wrMaskSet = wrPending_ff & (wrIndex_ff == `IDX_MASK_SET);
  assign wrMaskClear = wrPending_ff & (wrIndex_ff == `IDX_MASK_CLEAR);
  assign wrSoftSet = wrPending_ff & (wrIndex_ff == `IDX_SOFT_SET);
  assign wrSoftClear = wrPending_ff & (wrIndex_ff == `IDX_SOFT_CLEAR);
  assign wrAssignLow = wrPending_ff & (wrIndex_ff == `IDX_ASSIGN_LOW);
  assign wrAssignHigh = wrPending_ff & (wrIndex_ff == `IDX_ASSIGN_HIGH);
  assign wrCounterAssign = wrPending_ff & (wrIndex_ff == `IDX_COUNTER_ASSIGN);
  assign wrLineDrive = wrPending_ff & (wrIndex_ff == `IDX_LINE_DRIVE);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // A read right behind a write to the same word still returns the old value
  always @* begin
    rdValue = 32'h00000000;
    if (addrIndex == `IDX_PROC_PENDING) begin
      rdValue = pendingWord;
    end else if (addrIndex == `IDX_MASK_READ) begin
      rdValue = mask_ff & `MASK_DEFINED;
    end else if (addrIndex == `IDX_ASSIGN_LOW) begin
      rdValue = {16'h0000, assignLow_ff};
    end else if (addrIndex == `IDX_ASSIGN_HIGH) begin
      rdValue = {16'h0000, assignHigh_ff};
    end else if (addrIndex == `IDX_COUNTER_ASSIGN) begin
      rdValue = {24'h000000, counterAssign_ff};
    end else if (addrIndex == `IDX_LINE_DRIVE) begin
      rdValue = {24'h000000, lineDrive_ff};
    end
    // Set and clear ports, and unmapped words, read zero
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      // Captured at the address phase, stands during the data phase
      hrdata <= rdValue;
    end
  end

  // ----------------------------------------------------------------
  // Target mask
  // ----------------------------------------------------------------
  always @* begin
    nxt_mask = mask_ff;
    // Set and clear are separate words, so one write never does both
    if (wrMaskSet) begin
      nxt_mask = mask_ff | (hwdata & `MASK_DEFINED);
    end else if (wrMaskClear) begin
      nxt_mask = mask_ff & ~(hwdata & `MASK_DEFINED);
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      // Error masks and the low level masks start set
      mask_ff <= {`MASK_ERR_RESET, 10'h000, `MASK_HW_RESET, 1'b0};
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------------------------------
  // Software interrupts
  // ----------------------------------------------------------------
  always @* begin
    nxt_softPend = softPend_ff;
    // Bit 0 of both words is reserved and ignored
    if (wrSoftClear) begin
      nxt_softPend = softPend_ff & ~hwdata[15:1];
    end else if (wrSoftSet) begin
      nxt_softPend = softPend_ff | hwdata[15:1];
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      softPend_ff <= 15'h0000;
    end else begin
      softPend_ff <= nxt_softPend;
    end
  end

  // ----------------------------------------------------------------
  // Level assignment and line drive registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      assignLow_ff <= `ASSIGN_LOW_RESET;
      assignHigh_ff <= `ASSIGN_HIGH_RESET;
      counterAssign_ff <= `COUNTER_ASSIGN_RESET;
      lineDrive_ff <= `LINE_DRIVE_RESET;
    end else begin
      if (wrAssignLow) begin
        assignLow_ff <= hwdata[15:0];
      end else if (wrAssignHigh) begin
        assignHigh_ff <= hwdata[15:0];
      end else if (wrCounterAssign) begin
        counterAssign_ff <= hwdata[7:0];
      end else if (wrLineDrive) begin
        lineDrive_ff <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain line drive
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      intLineOut <= 8'h00;
      intLineOe <= 8'h00;
    end else begin
      // Only ever pulls low; the external pull-up makes the high level
      intLineOut <= 8'h00;
      // Drive register bit n enables the pull-down of line n
      intLineOe <= lineDrive_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bus reset detection latch
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      busResetSeen_ff <= 1'b0;
    end else if (busResetIn) begin
      // Detection wins over a clear, and a clear cannot act while asserted
      busResetSeen_ff <= 1'b1;
    end else if (busResetClear) begin
      busResetSeen_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hardware level mapping
  // ----------------------------------------------------------------
  // Sampled from the wired level, so self-driven and foreign drives both count
  assign lineActive = {sysCounterIrq, procCounterIrq, ~intLineIn_n};
  // Counter sources occupy entries 8 and 9, after the eight lines
  assign lineLevel = {counterAssign_ff, assignHigh_ff, assignLow_ff};

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gMap
      irq_line_map uMap (
        .active(lineActive[g]),
        .level(lineLevel[4*g +: 4]),
        .levelHot(levelHotAll[15*g +: 15])
      );
    end
  endgenerate

  always @* begin
    hwLevels = 15'h0000;
    for (i = 0; i < 10; i = i + 1) begin
      hwLevels = hwLevels | levelHotAll[15*i +: 15];
    end
  end

  // ----------------------------------------------------------------
  // Error sources at the fixed top level
  // ----------------------------------------------------------------
  // Bit order follows mask bits 30 down to 26
  assign errPending = {errPio, errDma, errSerr, errProc, busResetSeen_ff};
  // Each error has its own mask bit; the level field masks do not apply
  assign errAny = |(errPending & ~mask_ff[30:26]);

  // ----------------------------------------------------------------
  // Masking and pending status
  // ----------------------------------------------------------------
  // Masks act per level, after mapping, so a masked line is blocked here
  assign maskAll = mask_ff[`MASK_ALL_BIT];
  assign hwUnmasked = ((hwLevels & ~mask_ff[15:1]) | {errAny, 14'h0000})
    & {15{~maskAll}};
  assign softUnmasked = softPend_ff & {15{~maskAll}};
  assign pendingWord = {softUnmasked, 1'b0, hwUnmasked, 1'b0};

  // ----------------------------------------------------------------
  // Priority encode
  // ----------------------------------------------------------------
  irq_level_encode uEncode (
    .levelVec(softUnmasked | hwUnmasked),
    .levelCode(levelCode)
  );

  assign gatedLevel = maskAll ? 4'h0 : levelCode;

  // ----------------------------------------------------------------
  // Core level filter
  // ----------------------------------------------------------------
  // A code reaches the core only once two consecutive samples agree,
  // trading one extra cycle of latency for glitch immunity
  always @(posedge sys_clk) begin
    if (!rstn) begin
      levelSample_ff <= 4'h0;
      coreInterruptLevel <= 4'h0;
    end else begin
      levelSample_ff <= gatedLevel;
      if (levelSample_ff == gatedLevel) begin
        coreInterruptLevel <= gatedLevel;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/irq_level_encode.v ====
// Encodes the highest set bit of a level vector into a 4-bit level code
`timescale 1ns/1ps
`default_nettype none

module irq_level_encode (
  // Level vector, bit k-1 is level k
  input wire [14:0] levelVec,
  // Highest level present, zero when none
  output reg [3:0] levelCode
);

  integer k;

  always @* begin
    levelCode = 4'h0;
    // Ascending scan: the last hit is the highest level
    for (k = 1; k < 16; k = k + 1) begin
      if (levelVec[k - 1]) begin
        levelCode = k[3:0];
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/irq_line_map.v ====
// Maps one active interrupt source onto a one-hot vector of priority levels 15..1
`timescale 1ns/1ps
`default_nettype none

module irq_line_map (
  // Source
  input wire active,
  input wire [3:0] level,
  // Level vector, bit k-1 is level k
  output reg [14:0] levelHot
);

  integer k;

  always @* begin
    levelHot = 15'h0000;
    // Level zero selects no bit, so the source stays disabled
    for (k = 1; k < 16; k = k + 1) begin
      if (active && (level == k[3:0])) begin
        levelHot[k - 1] = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== pkg/irq_ctrl_map.vh ====
// Register indices, field positions and reset values of the interrupt controller
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PROC_PENDING 10'h064
`define IDX_SOFT_CLEAR 10'h06A
`define IDX_SOFT_SET 10'h06E
`define IDX_MASK_READ 10'h074
`define IDX_MASK_CLEAR 10'h078
`define IDX_MASK_SET 10'h07C
`define IDX_ASSIGN_LOW 10'h088
`define IDX_ASSIGN_HIGH 10'h08C
`define IDX_LINE_DRIVE 10'h08E
`define IDX_COUNTER_ASSIGN 10'h090

// ----------------------------------------------------------------
// Mask register fields
// ----------------------------------------------------------------
`define MASK_ALL_BIT 31
`define MASK_PIO_BIT 30
`define MASK_DMA_BIT 29
`define MASK_SERR_BIT 28
`define MASK_PROC_BIT 27
`define MASK_BUSRST_BIT 26
`define MASK_ERR_RESET 6'h3F
`define MASK_HW_RESET 15'h007F
`define MASK_DEFINED 32'hFC00FFFE

// ----------------------------------------------------------------
// Levels and reset assignments
// ----------------------------------------------------------------
`define LEVEL_ERROR 4'hF
`define ASSIGN_LOW_RESET 16'h7532
`define ASSIGN_HIGH_RESET 16'h0000
`define COUNTER_ASSIGN_RESET 8'h00
`define LINE_DRIVE_RESET 8'h00

`endif

// ==== verification/irq_controller_checker.sv ====
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

module irq_controller_checker #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Outputs
  input wire logic [7:0] intLineOe,
  input wire logic [3:0] coreInterruptLevel
);
  // ----------------------------------------
  // Shadow of bus accesses
  // ----------------------------------------
  wire logic [9:0] idx = haddr[11:2];
  wire logic wrTake = hsel & htrans[1] & hready & hwrite;
  wire logic rdTake = hsel & htrans[1] & hready & !hwrite;
  logic wrDrv_ff, wrSet_ff, wrClr_ff, rdMask_ff, rdPend_ff, rdWo_ff, maskAll_ff;
  logic [7:0] drvVal_ff;
  always @(posedge sys_clk) begin
    if (!rstn) begin
      {wrDrv_ff, wrSet_ff, wrClr_ff, rdMask_ff, rdPend_ff, rdWo_ff, maskAll_ff} <= 7'h01;
    end else begin
      wrDrv_ff <= wrTake && idx == `IDX_LINE_DRIVE;
      wrSet_ff <= wrTake && idx == `IDX_MASK_SET;
      wrClr_ff <= wrTake && idx == `IDX_MASK_CLEAR;
      rdMask_ff <= rdTake && idx == `IDX_MASK_READ;
      rdPend_ff <= rdTake && idx == `IDX_PROC_PENDING;
      rdWo_ff <= rdTake && (idx == `IDX_SOFT_SET || idx == `IDX_SOFT_CLEAR || idx == `IDX_MASK_SET);
      if (wrDrv_ff) drvVal_ff <= hwdata[7:0];
      // Set and clear never share a cycle, so order is free
      if (wrSet_ff && hwdata[31]) maskAll_ff <= 1'b1;
      else if (wrClr_ff && hwdata[31]) maskAll_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> coreInterruptLevel == 4'h0 && intLineOe == 8'h00)
    else $error("level or drive not cleared by reset");
  drive_update_a: assert property (wrDrv_ff |=> ##1 intLineOe == $past(drvVal_ff))
    else $error("line drive did not follow write");
  drive_hold_a: assert property (!wrDrv_ff && !$past(wrDrv_ff) |=> $stable(intLineOe))
    else $error("line drive changed without write");
  mask_resv_a: assert property (rdMask_ff |-> (hrdata & ~`MASK_DEFINED) == 32'h0)
    else $error("mask reserved bits set");
  pend_resv_a: assert property (rdPend_ff |-> {hrdata[16], hrdata[0]} == 2'h0)
    else $error("pending reserved bits set");
  pend_maskall_a: assert property (rdPend_ff && $past(maskAll_ff) |-> hrdata == 32'h0)
    else $error("pending shown while all masked");
  wo_read_zero_a: assert property (rdWo_ff |-> hrdata == 32'h0)
    else $error("write-only place read nonzero");
  maskall_level_a: assert property (maskAll_ff [*3] |-> coreInterruptLevel == 4'h0)
    else $error("level shown while all masked");
endmodule

bind irq_controller irq_controller_checker #(.ADDR_W(ADDR_W)) chk (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .intLineOe(intLineOe), .coreInterruptLevel(coreInterruptLevel));
`default_nettype wire

// ==== verification/irq_far_side.sv ====
// Shared interrupt wires and the core's level sampler
`timescale 1ns/1ps
`default_nettype none

module irq_far_side (
  // Clock
  input wire logic sys_clk,
  // Device side
  input wire logic [7:0] intLineOe,
  input wire logic [3:0] coreInterruptLevel,
  // Other drivers, high pulls a line low
  input wire logic [7:0] extDrive,
  output logic [7:0] intLineIn_n,
  output logic [3:0] takenLevel_ff
);
  logic [3:0] sample_ff;
  // Pull-up returns a released line high
  assign intLineIn_n = ~(intLineOe | extDrive);
  always @(posedge sys_clk) begin
    sample_ff <= coreInterruptLevel;
    if (sample_ff == coreInterruptLevel) takenLevel_ff <= sample_ff;
  end
endmodule
`default_nettype wire

// ==== verification/irq_mask_pending_swint_output_tb.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module irq_mask_pending_swint_output_tb;
  // Register indices; the byte address is four times the index
  localparam [9:0] PEND = 10'h064, SCLR = 10'h06A, SSET = 10'h06E, MRD = 10'h074, MCLR = 10'h078;
  localparam [9:0] MSET = 10'h07C, ALO = 10'h088, DRV = 10'h08E, CNT = 10'h090;
  logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, brIn = 1'b0, brClr = 1'b0, hreadyout, resp;
  logic [3:0] err = 4'h0, lvl, taken;
  logic [1:0] cnt = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [7:0] ext = 8'h00, lineIn_n, oe, lineOut;
  int numErrors = 0, checksDone = 0, cycles = 0;
  // Rows: mask clear, other drivers, {errors, bus reset}, soft set, pending, level
  logic [31:0] rClr [11] = '{32'h80000000, 32'h80000004, 32'h800000AC, 32'h80000000, 32'h80000020,
    32'hC0000000, 32'h80000000, 32'h0, 32'h84000000, 32'hB8000000, 32'h800000FE};
  logic [7:0] rExt [11] = '{8'h01, 8'h01, 8'h0F, 8'h0, 8'h04, 8'h0, 8'h0, 8'h0F, 8'h0, 8'h0, 8'hF0};
  logic [4:0] rErr [11] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h10, 5'h10, 5'h0, 5'h01, 5'h0E, 5'h0};
  logic [15:0] rSoft [11] = '{16'h0, 16'h0, 16'h0, 16'h8, 16'h10, 16'h0, 16'h0, 16'h8000, 16'h0, 16'h0, 16'h0};
  logic [31:0] rPend [11] = '{32'h0, 32'h4, 32'hAC, 32'h80000, 32'h100020, 32'h8000, 32'h0, 32'h0, 32'h8000,
    32'h8000, 32'h0};
  logic [3:0] rLvl [11] = '{4'h0, 4'h2, 4'h7, 4'h3, 4'h5, 4'hF, 4'h0, 4'h0, 4'hF, 4'hF, 4'h0};

  irq_controller dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(resp), .hrdata(hrdata),
    .errPio(err[3]), .errDma(err[2]), .errSerr(err[1]), .errProc(err[0]), .busResetIn(brIn), .busResetClear(brClr),
    .procCounterIrq(cnt[0]), .sysCounterIrq(cnt[1]), .intLineIn_n(lineIn_n), .intLineOut(lineOut), .intLineOe(oe),
    .coreInterruptLevel(lvl));
  irq_far_side far (.sys_clk(sys_clk), .intLineOe(oe), .coreInterruptLevel(lvl), .extDrive(ext),
    .intLineIn_n(lineIn_n), .takenLevel_ff(taken));

  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      numErrors++;
      tallyAndFinish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want) begin
      numErrors++;
      $display("ERROR %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    haddr <= {a, 2'h0};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  // Idle cycle first; bus ends a write's data phase before returning, so a read straight after it already sees the new value
  task automatic rc(input logic [9:0] a, input logic [31:0] want);
    @(posedge sys_clk);
    bus(a, 1'b0, 32'h0);
    check(rd, want);
  endtask
  task automatic st;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic lv(input logic [3:0] want);
    check({28'h0, lvl}, {28'h0, want});
  endtask
  task automatic pulseClr;
    brClr <= 1'b1;
    @(posedge sys_clk);
    brClr <= 1'b0;
  endtask
  task automatic tallyAndFinish;
    $display("errors %0d, checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      ext <= rExt[i];
      {err, brIn} <= rErr[i];
      bus(MCLR, 1'b1, rClr[i]);
      bus(SSET, 1'b1, {16'h0, rSoft[i]});
      st();
      rc(PEND, rPend[i]);
      lv(rLvl[i]);
      check({28'h0, taken}, {28'h0, rLvl[i]});
      ext <= 8'h00;
      {err, brIn} <= 5'h0;
      bus(MSET, 1'b1, 32'hFFFFFFFF);
      bus(SCLR, 1'b1, 32'h0000FFFF);
      pulseClr();
      st();
    end
    rc(MRD, 32'hFC00FFFE);
    bus(MCLR, 1'b1, 32'h00000006);
    bus(MSET, 1'b1, 32'h00000002);
    rc(MRD, 32'hFC00FFFA);
    bus(DRV, 1'b1, 32'h00000001);
    rc(DRV, 32'h00000001);
    check({24'h0, oe}, 32'h00000001);
    check({23'h0, resp, lineOut}, 32'h00000000);
    bus(MCLR, 1'b1, 32'h80000000);
    st();
    lv(4'h2);
    bus(MSET, 1'b1, 32'h00000004);
    st();
    lv(4'h0);
    bus(ALO, 1'b1, 32'h00007539);
    bus(MCLR, 1'b1, 32'h00000200);
    st();
    lv(4'h9);
    ext <= 8'h01;
    bus(DRV, 1'b1, 32'h0);
    st();
    lv(4'h9);
    ext <= 8'h00;
    st();
    lv(4'h0);
    ext <= 8'h01;
    @(posedge sys_clk);
    ext <= 8'h00;
    repeat (4) begin
      @(negedge sys_clk);
      lv(4'h0);
    end
    @(posedge sys_clk);
    bus(MCLR, 1'b1, 32'h04000000);
    brIn <= 1'b1;
    @(posedge sys_clk);
    brIn <= 1'b0;
    st();
    lv(4'hF);
    pulseClr();
    st();
    lv(4'h0);
    bus(DRV, 1'b1, 32'h00000080);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rc(MRD, 32'hFC0000FE);
    rc(PEND, 32'h0);
    rc(DRV, 32'h0);
    rc(SSET, 32'h0);
    rc(MCLR, 32'h0);
    rc(SCLR, 32'h0);
    cnt <= 2'h3;
    bus(MCLR, 1'b1, 32'h80000000);
    rc(PEND, 32'h0);
    bus(CNT, 1'b1, 32'h000000A4);
    st();
    rc(PEND, 32'h00000400);
    lv(4'hA);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
